/* dmf_diag_monitor_flags.sv */
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Temperature reading readable as two bytes at addresses 22 and 23.
// - Supply voltage reading readable as two bytes at addresses 26 and 27.
// - Four tx bias readings as byte pairs from 42-43 up to 48-49.
// - Four rx power readings as byte pairs from 34-35 up to 40-41.
// - Each attribute has alarm and warning limits setting flags.
// - Flags stay latched after the cause leaves, until cleared.
// - One mask bit per flag keeps that flag off the interrupt.
// - Mask bits are volatile, lost at power-down.
// - Reading a flag byte clears the latched flags it holds.
// - Dedicated interrupt output announces alarm, warning, LOS, fault.
// - Device is serial bus slave only; host drives the clock.
module dmf_diag_monitor_flags
   import dmf_pkg::*;
(
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic [NUM_ATTR-1:0][15:0] meas_i,
   input wire logic [NUM_CH-1:0] rx_los_i,
   input wire logic [NUM_CH-1:0] tx_los_i,
   input wire logic [NUM_CH-1:0] tx_fault_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic host_interrupt_n_o
);

   // =========================================================
   // Serial port
   dmf_req_t req;
   logic [7:0] rd_byte;

   dmf_two_wire_slave u_port
   (
      .clock_i (clock_i),
      .srst_i (srst_i),
      .scl_i (scl_i),
      .sda_i (sda_i),
      .rsp_data_i (rd_byte),
      .req_o (req),
      .sda_oe_o (sda_oe_o)
   );

   // Open drain: only ever pulls low
   assign sda_o = 1'b0;

   // =========================================================
   // Threshold storage
   logic [15:0] thr_reg [NUM_GRP][NUM_THR];
   logic [7:0] thr_stage_reg;
   wire thr_hit = (req.addr[7:5] == THR_AREA);
   wire [1:0] thr_g = req.addr[4:3];
   wire [1:0] thr_k = req.addr[2:1];
   wire thr_lsb = req.addr[0];
   wire [15:0] thr_word = thr_reg[thr_g][thr_k];
   wire [7:0] thr_byte = thr_lsb ? thr_word[7:0] : thr_word[15:8];
   wire thr_wr = req.wr & thr_hit;

   // MSB is staged so limits never compare half-written
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         thr_stage_reg <= '0;
      else if (thr_wr && !thr_lsb)
         thr_stage_reg <= req.wdata;
   end

   genvar g, k;
   generate
      for (g = 0; g < NUM_GRP; g++)
      begin : g_grp
         for (k = 0; k < NUM_THR; k++)
         begin : g_thr
            localparam logic [15:0] RST_VAL =
               (k == THR_HI_ALM || k == THR_HI_WRN) ?
               GRP_HI_RST[g] : GRP_LO_RST[g];
            wire sel = thr_wr & thr_lsb & (thr_g == 2'(g)) &
               (thr_k == 2'(k));

            always_ff @(posedge clock_i)
            begin
               if (srst_i)
                  thr_reg[g][k] <= RST_VAL;
               else if (sel)
                  thr_reg[g][k] <= {thr_stage_reg, req.wdata};
            end
         end
      end
   endgenerate

   // =========================================================
   // Attribute monitors, flags and masks
   logic [3:0] flag_reg [NUM_ATTR];
   logic [3:0] mask_reg [NUM_ATTR];
   logic [NUM_ATTR-1:0] attr_pend;
   logic [NUM_ATTR-1:0] val_msb_hit;
   logic [NUM_ATTR-1:0] val_lsb_hit;
   logic [NUM_ATTR:0][7:0] attr_chain;
   logic [NUM_ATTR:0][7:0] low_chain;

   assign attr_chain[0] = 8'h00;
   assign low_chain[0] = 8'h00;

   genvar a;
   generate
      for (a = 0; a < NUM_ATTR; a++)
      begin : g_attr
         wire [15:0] val = meas_i[a];
         wire [1:0] grp = ATTR_GRP[a];
         wire [15:0] hi_alm = thr_reg[grp][THR_HI_ALM];
         wire [15:0] lo_alm = thr_reg[grp][THR_LO_ALM];
         wire [15:0] hi_wrn = thr_reg[grp][THR_HI_WRN];
         wire [15:0] lo_wrn = thr_reg[grp][THR_LO_WRN];
         logic [3:0] over;
         wire flag_hit = (req.addr == 8'(FLAG_BASE + a));
         wire mask_hit = (req.addr == 8'(MASK_BASE + a));
         wire flag_clr = req.rd & flag_hit;
         wire [3:0] flag_next;
         wire [7:0] part;

         // Limit comparison per attribute
         if (ATTR_SIGNED[a])
         begin : g_sgn
            assign over[THR_HI_ALM] = $signed(val) > $signed(hi_alm);
            assign over[THR_LO_ALM] = $signed(val) < $signed(lo_alm);
            assign over[THR_HI_WRN] = $signed(val) > $signed(hi_wrn);
            assign over[THR_LO_WRN] = $signed(val) < $signed(lo_wrn);
         end
         else
         begin : g_uns
            assign over[THR_HI_ALM] = val > hi_alm;
            assign over[THR_LO_ALM] = val < lo_alm;
            assign over[THR_HI_WRN] = val > hi_wrn;
            assign over[THR_LO_WRN] = val < lo_wrn;
         end

         // Sticky; a new event beats a read clear
         assign flag_next = (flag_reg[a] & ~{4{flag_clr}}) | over;

         always_ff @(posedge clock_i)
         begin
            if (srst_i)
               flag_reg[a] <= FLAG_RST;
            else
               flag_reg[a] <= flag_next;
         end

         // Volatile, cleared at reset
         always_ff @(posedge clock_i)
         begin
            if (srst_i)
               mask_reg[a] <= MASK_RST;
            else if (req.wr && mask_hit)
               mask_reg[a] <= req.wdata[3:0];
         end

         // Masked flags drop out of the interrupt
         assign attr_pend[a] = |(flag_reg[a] & ~mask_reg[a]);

         // Value byte pairs, MSB first
         assign val_msb_hit[a] = (req.addr == VAL_ADDR[a]);
         assign val_lsb_hit[a] = (req.addr == 8'(VAL_ADDR[a] + 8'h01));
         assign part = ({8{val_msb_hit[a]}} & val[15:8]) |
            ({8{val_lsb_hit[a]}} & val[7:0]) |
            ({8{flag_hit}} & {4'h0, flag_reg[a]}) |
            ({8{mask_hit}} & {4'h0, mask_reg[a]});
         assign attr_chain[a+1] = attr_chain[a] | part;
         assign low_chain[a+1] = low_chain[a] |
            ({8{val_msb_hit[a]}} & val[7:0]);
      end
   endgenerate

   // =========================================================
   // Loss of signal and transmit fault events
   logic [NUM_CH-1:0] evt_flag_reg [NUM_EVT];
   logic [NUM_CH-1:0] evt_mask_reg [NUM_EVT];
   logic [NUM_EVT-1:0] evt_pend;
   logic [NUM_EVT:0][7:0] evt_chain;
   wire [NUM_EVT-1:0][NUM_CH-1:0] evt_in = {tx_fault_i, tx_los_i,
      rx_los_i};

   assign evt_chain[0] = 8'h00;

   genvar e;
   generate
      for (e = 0; e < NUM_EVT; e++)
      begin : g_evt
         wire flag_hit = (req.addr == 8'(EVT_FLAG_BASE + e));
         wire mask_hit = (req.addr == 8'(EVT_MASK_BASE + e));
         wire flag_clr = req.rd & flag_hit;
         wire [NUM_CH-1:0] flag_next =
            (evt_flag_reg[e] & ~{NUM_CH{flag_clr}}) | evt_in[e];

         // Same latch and read-clear policy
         always_ff @(posedge clock_i)
         begin
            if (srst_i)
               evt_flag_reg[e] <= FLAG_RST;
            else
               evt_flag_reg[e] <= flag_next;
         end

         always_ff @(posedge clock_i)
         begin
            if (srst_i)
               evt_mask_reg[e] <= MASK_RST;
            else if (req.wr && mask_hit)
               evt_mask_reg[e] <= req.wdata[NUM_CH-1:0];
         end

         assign evt_pend[e] = |(evt_flag_reg[e] & ~evt_mask_reg[e]);
         assign evt_chain[e+1] = evt_chain[e] |
            ({8{flag_hit}} & {4'h0, evt_flag_reg[e]}) |
            ({8{mask_hit}} & {4'h0, evt_mask_reg[e]});
      end
   endgenerate

   // =========================================================
   // Coherent two-byte reads
   // The low byte is frozen when the high byte is fetched, so a
   // pair read back to back always belongs to one sample.
   logic [7:0] hold_reg;
   logic [7:0] hold_addr_reg;
   logic hold_valid_reg;
   wire msb_any = |val_msb_hit;
   wire lsb_any = |val_lsb_hit;
   wire use_hold = hold_valid_reg & lsb_any &
      (req.addr == hold_addr_reg);

   // Relies on the host keeping the pair in one read
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         hold_reg <= '0;
         hold_addr_reg <= '0;
         hold_valid_reg <= 1'b0;
      end
      else if (req.rd)
      begin
         hold_reg <= low_chain[NUM_ATTR];
         hold_addr_reg <= 8'(req.addr + 8'h01);
         hold_valid_reg <= msb_any;
      end
   end

   // =========================================================
   // Read data select; unmapped bytes read as zero
   wire [7:0] live_byte = attr_chain[NUM_ATTR] | evt_chain[NUM_EVT];

   assign rd_byte = use_hold ? hold_reg :
      thr_hit ? thr_byte : live_byte;

   // =========================================================
   // Interrupt output
   logic irq_n_reg;
   wire irq_any = (|attr_pend) | (|evt_pend);

   // Active low while anything unmasked is latched
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         irq_n_reg <= IRQ_N_IDLE;
      else
         irq_n_reg <= ~irq_any;
   end

   assign host_interrupt_n_o = irq_n_reg;

endmodule // dmf_diag_monitor_flags

`default_nettype wire

/* dmf_pkg.sv */
package dmf_pkg;

   // =========================================================
   // Sizes
   localparam int NUM_ATTR = 10;
   localparam int NUM_GRP = 4;
   localparam int NUM_THR = 4;
   localparam int NUM_CH = 4;
   localparam int NUM_EVT = 3;

   // =========================================================
   // Serial port
   // Bus address is arbitrary
   localparam logic [6:0] DEV_ADDR = 7'h50;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic BUS_IDLE = 1'b1;
   localparam logic IRQ_N_IDLE = 1'b1;

   // =========================================================
   // Monitor value byte addresses, MSB at the lower address
   localparam logic [7:0] TEMP_OFS = 8'h16;
   localparam logic [7:0] VCC_OFS = 8'h1A;
   localparam logic [7:0] RXP1_OFS = 8'h22;
   localparam logic [7:0] RXP2_OFS = 8'h24;
   localparam logic [7:0] RXP3_OFS = 8'h26;
   localparam logic [7:0] RXP4_OFS = 8'h28;
   localparam logic [7:0] TXB1_OFS = 8'h2A;
   localparam logic [7:0] TXB2_OFS = 8'h2C;
   localparam logic [7:0] TXB3_OFS = 8'h2E;
   localparam logic [7:0] TXB4_OFS = 8'h30;
   localparam logic [NUM_ATTR-1:0][7:0] VAL_ADDR = {TXB4_OFS, TXB3_OFS,
      TXB2_OFS, TXB1_OFS, RXP4_OFS, RXP3_OFS, RXP2_OFS, RXP1_OFS,
      VCC_OFS, TEMP_OFS};

   // =========================================================
   // Flag, mask and threshold areas
   localparam logic [7:0] FLAG_BASE = 8'h03;
   localparam logic [7:0] EVT_FLAG_BASE = 8'h0D;
   localparam logic [7:0] MASK_BASE = 8'h64;
   localparam logic [7:0] EVT_MASK_BASE = 8'h6E;
   localparam logic [2:0] THR_AREA = 3'h4;
   localparam logic [3:0] MASK_RST = 4'h0;
   localparam logic [3:0] FLAG_RST = 4'h0;

   // =========================================================
   // Threshold and flag bit positions
   localparam int THR_HI_ALM = 0;
   localparam int THR_LO_ALM = 1;
   localparam int THR_HI_WRN = 2;
   localparam int THR_LO_WRN = 3;

   // Groups: temperature, supply, rx power, tx bias
   localparam logic [1:0] GRP_TEMP = 2'h0;
   localparam logic [1:0] GRP_VCC = 2'h1;
   localparam logic [1:0] GRP_RXP = 2'h2;
   localparam logic [1:0] GRP_TXB = 2'h3;
   localparam logic [NUM_ATTR-1:0][1:0] ATTR_GRP = {GRP_TXB, GRP_TXB,
      GRP_TXB, GRP_TXB, GRP_RXP, GRP_RXP, GRP_RXP, GRP_RXP, GRP_VCC,
      GRP_TEMP};
   // Temperature is two's complement
   localparam logic [NUM_ATTR-1:0] ATTR_SIGNED = 10'h001;
   localparam logic [NUM_GRP-1:0][15:0] GRP_HI_RST = {16'hFFFF,
      16'hFFFF, 16'hFFFF, 16'h7FFF};
   localparam logic [NUM_GRP-1:0][15:0] GRP_LO_RST = {16'h0000,
      16'h0000, 16'h0000, 16'h8000};

   // =========================================================
   // Types
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dmf_req_t;

   typedef enum logic [3:0] {
      TW_IDLE,
      TW_ADDR,
      TW_ADDR_ACK,
      TW_PTR,
      TW_PTR_ACK,
      TW_WDATA,
      TW_WDATA_ACK,
      TW_RDATA,
      TW_RDATA_ACK
   } dmf_tw_state_t;

endpackage

/* dmf_two_wire_slave.sv */
`timescale 1ns/10ps
`default_nettype none

module dmf_two_wire_slave
   import dmf_pkg::*;
(
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic [7:0] rsp_data_i,
   output dmf_req_t req_o,
   output logic sda_oe_o
);

   // =========================================================
   // Pin synchronisers and edge detection
   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic scl_q_reg;
   logic sda_q_reg;
   wire scl_s = scl_sync_reg[1];
   wire sda_s = sda_sync_reg[1];
   wire scl_rise = scl_s & ~scl_q_reg;
   wire scl_fall = ~scl_s & scl_q_reg;
   wire start_det = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
   wire stop_det = scl_s & scl_q_reg & ~sda_q_reg & sda_s;

   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         scl_sync_reg <= {2{BUS_IDLE}};
         sda_sync_reg <= {2{BUS_IDLE}};
         scl_q_reg <= BUS_IDLE;
         sda_q_reg <= BUS_IDLE;
      end
      else
      begin
         scl_sync_reg <= {scl_sync_reg[0], scl_i};
         sda_sync_reg <= {sda_sync_reg[0], sda_i};
         scl_q_reg <= scl_s;
         sda_q_reg <= sda_s;
      end
   end

   // =========================================================
   // Byte engine
   dmf_tw_state_t state_reg, state_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic [7:0] ptr_reg, ptr_next;
   logic rw_reg, rw_next;
   logic nack_reg, nack_next;
   logic oe_reg, oe_next;
   wire byte_done = (cnt_reg == BITS_PER_BYTE);

   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      ptr_next = ptr_reg;
      rw_next = rw_reg;
      nack_next = nack_reg;
      oe_next = oe_reg;
      req_o = '0;
      req_o.addr = ptr_reg;
      req_o.wdata = shift_reg;
      if (start_det)
      begin
         state_next = TW_ADDR;
         cnt_next = '0;
         oe_next = 1'b0;
      end
      else if (stop_det)
      begin
         state_next = TW_IDLE;
         oe_next = 1'b0;
      end
      else if (scl_rise)
      begin
         case (state_reg)
            TW_ADDR, TW_PTR, TW_WDATA:
            begin
               shift_next = {shift_reg[6:0], sda_s};
               cnt_next = cnt_reg + 4'h1;
            end
            TW_RDATA: cnt_next = cnt_reg + 4'h1;
            TW_RDATA_ACK: nack_next = sda_s;
            default: ;
         endcase
      end
      else if (scl_fall)
      begin
         case (state_reg)
            TW_ADDR:
               if (byte_done)
               begin
                  cnt_next = '0;
                  // Only answers, never masters the bus
                  if (shift_reg[7:1] == DEV_ADDR)
                  begin
                     state_next = TW_ADDR_ACK;
                     rw_next = shift_reg[0];
                     oe_next = 1'b1;
                  end
                  else
                     state_next = TW_IDLE;
               end
            TW_ADDR_ACK, TW_RDATA_ACK:
               if (state_reg == TW_RDATA_ACK && nack_reg)
               begin
                  state_next = TW_IDLE;
                  oe_next = 1'b0;
               end
               else if (state_reg == TW_RDATA_ACK || rw_reg)
               begin
                  // Byte fetched in this cycle; first bit out at once
                  req_o.rd = 1'b1;
                  ptr_next = ptr_reg + 8'h01;
                  shift_next = rsp_data_i;
                  oe_next = ~rsp_data_i[7];
                  state_next = TW_RDATA;
               end
               else
               begin
                  oe_next = 1'b0;
                  state_next = TW_PTR;
               end
            TW_PTR:
               if (byte_done)
               begin
                  cnt_next = '0;
                  ptr_next = shift_reg;
                  oe_next = 1'b1;
                  state_next = TW_PTR_ACK;
               end
            TW_WDATA:
               if (byte_done)
               begin
                  cnt_next = '0;
                  req_o.wr = 1'b1;
                  ptr_next = ptr_reg + 8'h01;
                  oe_next = 1'b1;
                  state_next = TW_WDATA_ACK;
               end
            TW_PTR_ACK, TW_WDATA_ACK:
            begin
               oe_next = 1'b0;
               state_next = TW_WDATA;
            end
            TW_RDATA:
               if (byte_done)
               begin
                  cnt_next = '0;
                  oe_next = 1'b0;
                  state_next = TW_RDATA_ACK;
               end
               else
               begin
                  shift_next = {shift_reg[6:0], 1'b0};
                  oe_next = ~shift_reg[6];
               end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         state_reg <= TW_IDLE;
         cnt_reg <= '0;
         shift_reg <= '0;
         ptr_reg <= '0;
         rw_reg <= 1'b0;
         nack_reg <= 1'b0;
         oe_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         ptr_reg <= ptr_next;
         rw_reg <= rw_next;
         nack_reg <= nack_next;
         oe_reg <= oe_next;
      end
   end

   assign sda_oe_o = oe_reg;

endmodule // dmf_two_wire_slave

`default_nettype wire

/* dmf_diag_monitor_flags_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================
// Pin and interrupt checks
module dmf_diag_monitor_flags_assertions
   import dmf_pkg::*;
(
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic [NUM_ATTR-1:0][15:0] meas_i,
   input wire logic [NUM_CH-1:0] rx_los_i,
   input wire logic [NUM_CH-1:0] tx_los_i,
   input wire logic [NUM_CH-1:0] tx_fault_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic host_interrupt_n_o
);
   logic quiet_reg;
   logic [2:0] still_reg;
   wire logic any_evt;
   default clocking cb @(posedge clock_i); endclocking
   assign any_evt = |{rx_los_i, tx_los_i, tx_fault_i};
   // Masks and limits keep reset values until the bus moves
   always_ff @(posedge clock_i)
   begin
      quiet_reg <= srst_i | (quiet_reg & scl_i);
      still_reg <= (srst_i || !scl_i) ? 3'h0 :
         still_reg + {2'h0, still_reg != 3'h7};
   end
   property p_rst_irq;
      srst_i |=> host_interrupt_n_o;
   endproperty
   a_rst_irq: assert property (p_rst_irq)
      else $error("interrupt active after reset");
   property p_rst_oe;
      srst_i |=> !sda_oe_o;
   endproperty
   a_rst_oe: assert property (p_rst_oe)
      else $error("data pin driven after reset");
   property p_sda_low;
      disable iff (srst_i) sda_oe_o |-> !sda_o;
   endproperty
   a_sda_low: assert property (p_sda_low)
      else $error("data pin driven high");
   property p_oe_stable;
      disable iff (srst_i) scl_i && $past(scl_i) |-> $stable(sda_oe_o);
   endproperty
   a_oe_stable: assert property (p_oe_stable)
      else $error("data changed while clock high");
   property p_oe_rise;
      disable iff (srst_i) $rose(sda_oe_o) |-> !scl_i && !$past(scl_i, 2);
   endproperty
   a_oe_rise: assert property (p_oe_rise)
      else $error("drive started too soon after clock fall");
   property p_evt_irq;
      disable iff (srst_i)
      quiet_reg && any_evt && !$past(srst_i) |-> ##2 !host_interrupt_n_o;
   endproperty
   a_evt_irq: assert property (p_evt_irq)
      else $error("event did not raise interrupt in 2 cycles");
   property p_quiet_high;
      disable iff (srst_i) quiet_reg && host_interrupt_n_o && !any_evt
      && !$past(any_evt) |=> host_interrupt_n_o;
   endproperty
   a_quiet_high: assert property (p_quiet_high)
      else $error("interrupt without cause");
   property p_irq_hold;
      disable iff (srst_i)
      still_reg >= 3'h4 && !host_interrupt_n_o |=> !host_interrupt_n_o;
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("interrupt released without bus access");
endmodule // dmf_diag_monitor_flags_assertions

bind dmf_diag_monitor_flags dmf_diag_monitor_flags_assertions
   dmf_diag_monitor_flags_assertions_inst (.clock_i, .srst_i, .meas_i,
   .rx_los_i, .tx_los_i, .tx_fault_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
   .host_interrupt_n_o);
`default_nettype wire

/* dmf_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================
// Host controller, bus master
module dmf_host_model
   import dmf_pkg::*;
(
   input wire logic clock_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_oe_o,
   output logic rd_stb_o,
   output logic [7:0] rd_data_o
);
   initial
   begin
      scl_o = BUS_IDLE;
      sda_oe_o = 1'b0;
      rd_stb_o = 1'b0;
      rd_data_o = 8'h00;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge clock_i);
   endtask
   // Low 24 ns so the slave has time to drive, high 8 ns
   task automatic bit_io(input logic b, output logic r);
      cyc(1);
      sda_oe_o = !b;
      cyc(5);
      scl_o = 1'b1;
      cyc(1);
      r = sda_i;
      cyc(1);
      scl_o = 1'b0;
   endtask
   task automatic start();
      cyc(1);
      sda_oe_o = 1'b0;
      cyc(2);
      scl_o = 1'b1;
      cyc(4);
      sda_oe_o = 1'b1;
      cyc(4);
      scl_o = 1'b0;
   endtask
   task automatic stop();
      cyc(1);
      sda_oe_o = 1'b1;
      cyc(2);
      scl_o = 1'b1;
      cyc(4);
      sda_oe_o = 1'b0;
      cyc(6);
   endtask
   task automatic put(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic get(input logic last);
      logic [7:0] d;
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(last, r);
      rd_data_o = d;
      rd_stb_o = 1'b1;
      cyc(1);
      rd_stb_o = 1'b0;
   endtask
   task automatic wr(input logic [6:0] dev, input logic [7:0] ptr,
      input logic [15:0] d, input int n, output logic ok);
      logic a0, a1, a2, a3;
      a2 = 1'b1;
      start();
      put({dev, 1'b0}, a0);
      put(ptr, a1);
      if (n == 2)
         put(d[15:8], a2);
      put(d[7:0], a3);
      stop();
      ok = a0 & a1 & a2 & a3;
   endtask
   // Whole value in one read keeps its bytes from one sample
   task automatic rd(input logic [7:0] ptr, input int n, output logic ok);
      logic a0, a1, a2;
      start();
      put({DEV_ADDR, 1'b0}, a0);
      put(ptr, a1);
      start();
      put({DEV_ADDR, 1'b1}, a2);
      for (int k = 0; k < n; k++)
         get(k == n - 1);
      stop();
      ok = a0 & a1 & a2;
   endtask
endmodule // dmf_host_model
`default_nettype wire

/* dmf_diag_monitor_flags_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module dmf_diag_monitor_flags_tb
   import dmf_pkg::*;
;
   localparam int CASE_ATTR [4] = '{6, 0, 1, 3};
   localparam logic [7:0] CASE_ADR [4] = '{8'h98, 8'h82, 8'h8C, 8'h96};
   localparam logic [15:0] CASE_THR [4] = '{16'h1000, 16'h0000,
      16'h4000, 16'h0050};
   localparam logic [15:0] CASE_BAD [4] = '{16'h1001, 16'hFFFF,
      16'h4001, 16'h004F};
   logic clock_i = 1'b0;
   logic srst_i = 1'b1;
   logic [NUM_ATTR-1:0][15:0] meas = {NUM_ATTR{16'h0100}};
   logic [2:0][3:0] evt = '0;
   logic d_sda, d_oe, irq_n, h_scl, h_oe, stb, ok;
   logic [7:0] rdat;
   logic [7:0] exp_q [$];
   wire logic sda_w;
   int failures = 0;
   int comparisons = 0;
   always #2 clock_i = !clock_i;
   // Open drain with pull-up
   assign sda_w = !(h_oe || (d_oe && !d_sda));
   dmf_diag_monitor_flags dmf_diag_monitor_flags_inst (
      .clock_i(clock_i), .srst_i(srst_i), .meas_i(meas),
      .rx_los_i(evt[0]), .tx_los_i(evt[1]), .tx_fault_i(evt[2]),
      .scl_i(h_scl), .sda_i(sda_w), .sda_o(d_sda), .sda_oe_o(d_oe),
      .host_interrupt_n_o(irq_n));
   dmf_host_model dmf_host_model_inst (.clock_i(clock_i), .sda_i(sda_w),
      .scl_o(h_scl), .sda_oe_o(h_oe), .rd_stb_o(stb), .rd_data_o(rdat));
   // ==========================
   // Helpers
   task automatic stop_test();
      $display("Comparisons %0d, failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      comparisons++;
      if (seen !== want)
      begin
         failures++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clock_i);
   endtask
   task automatic wait_irq(input logic lvl);
      int k = 0;
      while (irq_n !== lvl && k < 8)
      begin
         cyc(1);
         k++;
      end
      check({15'h0, irq_n}, {15'h0, lvl});
   endtask
   task automatic rd_exp(input logic [7:0] a, input logic [15:0] v, int n);
      if (n == 2)
         exp_q.push_back(v[15:8]);
      exp_q.push_back(v[7:0]);
      dmf_host_model_inst.rd(a, n, ok);
      check({15'h0, ok}, 16'h0001);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] v, int n);
      dmf_host_model_inst.wr(DEV_ADDR, a, v, n, ok);
      check({15'h0, ok}, 16'h0001);
   endtask
   task automatic cause(input int c, input int ch, input logic on);
      if (c < 3)
         evt[c][ch] = on;
      else
         meas[CASE_ATTR[c-3]] = on ? CASE_BAD[c-3] : CASE_THR[c-3];
   endtask
   task automatic do_reset();
      srst_i = 1'b1;
      cyc(6);
      srst_i = 1'b0;
      cyc(2);
      check({15'h0, irq_n}, 16'h0001);
      check({15'h0, d_oe}, 16'h0000);
   endtask
   // Fetched bytes are matched against the oldest note
   always @(posedge clock_i)
      if (stb === 1'b1)
         check(rdat, exp_q.size() ? exp_q.pop_front() : 16'hXXXX);
   initial
   begin
      repeat (100000) @(posedge clock_i);
      failures++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      stop_test();
   end
   // ==========================
   // Scenarios
   initial
   begin
      int ch;
      logic [7:0] fa, ma;
      void'($urandom(31));
      do_reset();
      // First case runs before any bus traffic
      for (int c = 0; c < 7; c++)
      begin
         if (c < 3)
         begin
            ch = $urandom % 4;
            fa = EVT_FLAG_BASE + c[7:0];
            ma = EVT_MASK_BASE + c[7:0];
         end
         else
         begin
            ch = c - 3;
            fa = FLAG_BASE + CASE_ATTR[ch][7:0];
            ma = MASK_BASE + CASE_ATTR[ch][7:0];
            wr(CASE_ADR[ch], CASE_THR[ch], 2);
         end
         cause(c, ch, 1'b1);
         wait_irq(1'b0);
         cyc(2);
         cause(c, ch, 1'b0);
         cyc(10);
         check({15'h0, irq_n}, 16'h0000);
         rd_exp(fa, 16'h0001 << ch, 1);
         wait_irq(1'b1);
         rd_exp(fa, 16'h0000, 1);
         wr(ma, 16'h0001 << ch, 1);
         cause(c, ch, 1'b1);
         cyc(10);
         check({15'h0, irq_n}, 16'h0001);
         cause(c, ch, 1'b0);
         rd_exp(fa, 16'h0001 << ch, 1);
         wr(ma, 16'h0000, 1);
         $display("Flag case %0d done", c);
      end
      wr(MASK_BASE, 16'h000F, 1);
      rd_exp(MASK_BASE, 16'h000F, 1);
      do_reset();
      rd_exp(MASK_BASE, 16'h0000, 1);
      $display("Mask reset test done");
      for (int i = 0; i < NUM_ATTR; i++)
         meas[i] = 16'($urandom);
      // Read-only bytes ignore writes
      wr(TEMP_OFS, 16'h5AA5, 2);
      for (int i = 0; i < NUM_ATTR; i++)
         rd_exp(VAL_ADDR[i], meas[i], 2);
      check({15'h0, irq_n}, 16'h0001);
      $display("Value read test done");
      dmf_host_model_inst.wr(DEV_ADDR ^ 7'h01, MASK_BASE, 16'h00FF, 1, ok);
      check({15'h0, ok}, 16'h0000);
      rd_exp(MASK_BASE, 16'h0000, 1);
      rd_exp(8'h50, 16'h0000, 1);
      $display("Address test done");
      stop_test();
   end
endmodule // dmf_diag_monitor_flags_tb
`default_nettype wire
